// File: rxel_pkg.sv
// Constants, field positions and state types for the receive event log.
// Assumes one system clock; every file imports this package whole.
package rxel_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register widths and bus shape
    localparam int REG_W = 16;
    localparam int PADDR_W = 16;
    localparam int PDATA_W = 32;
    localparam int EVT_N = 7;
    localparam int SRC_ADDR_W = 20;
    localparam logic [REG_W-1:0] REG_RST = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [PADDR_W-1:0] IDX_CTRL = 16'h3000;
    localparam logic [PADDR_W-1:0] IDX_STATUS = 16'h3002;
    localparam logic [PADDR_W-1:0] IDX_MISC_ID = 16'h3010;
    localparam logic [PADDR_W-1:0] IDX_MISC_CNT = 16'h3012;
    localparam logic [PADDR_W-1:0] IDX_UND_ID = 16'h3020;
    localparam logic [PADDR_W-1:0] IDX_UND_CNT = 16'h3022;
    localparam logic [PADDR_W-1:0] IDX_OVR_ID = 16'h3030;
    localparam logic [PADDR_W-1:0] IDX_OVR_CNT = 16'h3032;

    ////////////////////////////////////////////////////////////////////////
    // Status word fields
    localparam int STS_RSVD_MSB = 4;
    localparam int STS_EVT_LSB = 5;
    localparam int STS_EVT_MSB = 11;
    localparam int STS_MISC_MSB = 9;
    localparam int STS_MISC_WRAP = 12;
    localparam int STS_UND_WRAP = 13;
    localparam int STS_OVR_WRAP = 14;
    localparam int STS_SUMMARY = 15;

    // Control word fields
    localparam int CTL_SEL_MSB = 4;
    localparam int CTL_IE_LSB = 5;
    localparam int CTL_IE_MSB = 14;
    localparam int CTL_TEST = 15;

    // Positions inside the event input vector
    localparam int EV_UNDERRUN = 5;
    localparam int EV_OVERRUN = 6;
    localparam int EV_MISC_N = 5;

    // Part of the control structure address that is logged
    localparam int SRC_ID_LSB = 4;
    localparam int SRC_ID_MSB = 19;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [3:0] {
        RXEL_REG_CTRL,
        RXEL_REG_STATUS,
        RXEL_REG_MISC_ID,
        RXEL_REG_MISC_CNT,
        RXEL_REG_UND_ID,
        RXEL_REG_UND_CNT,
        RXEL_REG_OVR_ID,
        RXEL_REG_OVR_CNT,
        RXEL_REG_NONE
    } rxel_reg_t;

    typedef struct packed {
        logic [REG_W-1:0] ctrl;
        logic [REG_W-1:0] status;
        logic pready;
        logic pslverr;
        logic [REG_W-1:0] rdata;
        logic service;
    } rxel_main_t;

    typedef struct packed {
        logic [REG_W-1:0] id;
        logic [REG_W-1:0] count;
    } rxel_slot_t;

    // Byte address of a register index
    function automatic logic [PADDR_W-1:0] rxel_byte_addr(input logic [PADDR_W-1:0] idx);
        rxel_byte_addr = {idx[PADDR_W-3:0], 2'b00};
    endfunction

endpackage

// File: rxel_slot_if.sv
// Bundle between the register hub and one source-ID/counter slot.
// Assumes both ends run on the same clock.
interface rxel_slot_if;
    import rxel_pkg::*;

    logic inc;
    logic load;
    logic [REG_W-1:0] id_in;
    logic wr_id;
    logic wr_cnt;
    logic [REG_W-1:0] wdata;
    logic [REG_W-1:0] id;
    logic [REG_W-1:0] count;
    logic wrap;

    // Hub drives requests and reads back state
    modport hub(output inc, output load, output id_in, output wr_id, output wr_cnt,
        output wdata, input id, input count, input wrap);
    modport slot(input inc, input load, input id_in, input wr_id, input wr_cnt,
        input wdata, output id, output count, output wrap);
endinterface

// File: rxel_event_slot.sv
// One source-ID register and its event counter, with a wrap pulse.
// Assumes the hub gives at most one increment per cycle.
module rxel_event_slot
    import rxel_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    rxel_slot_if.slot sl
);

    if (CNT_W < 1 || CNT_W > REG_W) begin : g_cnt_w_bad
        $error("rxel_event_slot: CNT_W out of range");
    end

    rxel_slot_t st_r;
    rxel_slot_t st_nxt;
    logic at_top;

    ////////////////////////////////////////////////////////////////////////
    // Wrap is seen in the same cycle as the increment that causes it
    assign at_top = (st_r.count[CNT_W-1:0] == {CNT_W{1'b1}});
    assign sl.wrap = sl.inc & at_top & ~sl.wr_cnt; // [R18]
    assign sl.id = st_r.id;
    assign sl.count = st_r.count;

    // Software write wins over a same-cycle hardware update
    always_comb begin
        st_nxt = st_r;
        if (sl.wr_id) begin
            st_nxt.id = sl.wdata; // [R15]
        end else if (sl.load) begin
            st_nxt.id = sl.id_in;
        end
        if (sl.wr_cnt) begin
            st_nxt.count = sl.wdata; // [R15]
        end else if (sl.inc) begin
            st_nxt.count = REG_W'(CNT_W'(st_r.count[CNT_W-1:0] + 1'b1)); // [R18]
        end
    end

    // Synchronous reset clears both words
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_r <= '0; // [R15]
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

// File: rxel_event_log.sv
// Receive error event log: sticky status word, control word, and three
// source-ID/counter slots, reached by software over APB.
// Assumes event inputs come from the receive engine on clk_i.
//
// Contract
// R01 - Status bits 4:0 always read zero
// R02 - Bits 5..11 latch their receive error events
// R03 - Write one clears a bit; zero keeps
// R04 - Bits 12..14 latch on counter rollover
// R05 - Bit 15 set while any of 14:5
// R06 - Misc ID loads structure address bits 19:4
// R07 - Misc ID changes only for selected kinds
// R08 - Test bit updates all three source IDs
// R09 - Misc counter counts selected bits 9:5 events
// R10 - Test bit increments all three counters
// R11 - Underrun ID loads structure address bits 19:4
// R12 - Underrun counter counts every write underrun
// R13 - Overrun ID loads structure address bits 19:4
// R14 - Overrun counter counts every write overrun
// R15 - All zero after reset; IDs, counters writable
// R16 - Enabled status bits raise service flag
// R17 - Test bit forces every status event
// R18 - Counters wrap to zero, flag rollover
//
// Register map, byte address = 4 x index
//   0xC000 control
//     selects 4:0, enables 14:5, test 15
//   0xC008 status, write one to clear
//   0xC040 misc source ID
//   0xC048 misc event count
//   0xC080 underrun source ID
//   0xC088 underrun event count
//   0xC0C0 overrun source ID
//   0xC0C8 overrun event count
//   Bits 31:16 of every word read zero.
//
// Bus timing
//   No wait states: pready stands in the
//   first access cycle only.
//   Read data and pslverr are caught at
//   the setup edge, so a status read
//   shows the flags before that edge.
//   A write lands at the access edge,
//   byte lane by byte lane.
//   Unmapped words answer pslverr with
//   zero data and ignore writes.
//
// Event timing
//   evt_i is sampled at every edge.
//   An event shows in status, ID and
//   count right after its edge, and the
//   service flag in the same cycle.
//   Kinds that coincide share one
//   structure address and give one
//   misc increment.
//   A software write to an ID or count
//   beats an event in the same cycle:
//   that word misses the event; a count
//   write also drops the rollover.
//   An event beats a same-cycle clear.
//
// Test mode
//   While the test bit stands, all status
//   events repeat each cycle, the three
//   counters climb and the IDs follow
//   evt_addr_i. Keep it short: a long
//   stay wraps the counters.
//
// CNT_W below 16 makes the counters wrap early.
//
// Decided for this implementation: the APB interface to the registers.
module rxel_event_log
    import rxel_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [PADDR_W-1:0] paddr_i,
    input wire logic [PDATA_W-1:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [PDATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [EVT_N-1:0] evt_i,
    input wire logic [SRC_ADDR_W-1:0] evt_addr_i,
    output logic rx_path_service_flag_o
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    if (CNT_W < 1 || CNT_W > REG_W) begin : g_cnt_w_bad
        $error("rxel_event_log: CNT_W out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Map a byte address to a register; anything else is unmapped
    // Full compare, so no register shows through an alias
    function automatic rxel_reg_t decode(input logic [PADDR_W-1:0] a);
        rxel_reg_t r;
        r = RXEL_REG_NONE;
        if (a == rxel_byte_addr(IDX_CTRL)) begin
            r = RXEL_REG_CTRL;
        end else if (a == rxel_byte_addr(IDX_STATUS)) begin
            r = RXEL_REG_STATUS;
        end else if (a == rxel_byte_addr(IDX_MISC_ID)) begin
            r = RXEL_REG_MISC_ID;
        end else if (a == rxel_byte_addr(IDX_MISC_CNT)) begin
            r = RXEL_REG_MISC_CNT;
        end else if (a == rxel_byte_addr(IDX_UND_ID)) begin
            r = RXEL_REG_UND_ID;
        end else if (a == rxel_byte_addr(IDX_UND_CNT)) begin
            r = RXEL_REG_UND_CNT;
        end else if (a == rxel_byte_addr(IDX_OVR_ID)) begin
            r = RXEL_REG_OVR_ID;
        end else if (a == rxel_byte_addr(IDX_OVR_CNT)) begin
            r = RXEL_REG_OVR_CNT;
        end
        return r;
    endfunction

    // Byte-lane mask of the two low lanes that carry register data
    function automatic logic [REG_W-1:0] lane_mask(input logic [3:0] strb);
        return {{8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // Merge write data into an old value under the lane mask
    function automatic logic [REG_W-1:0] merge(
        input logic [REG_W-1:0] old,
        input logic [REG_W-1:0] wd,
        input logic [3:0] strb
    );
        logic [REG_W-1:0] m;
        m = lane_mask(strb);
        return (old & ~m) | (wd & m);
    endfunction

    // Logged part of a control structure address
    function automatic logic [REG_W-1:0] src_id(input logic [SRC_ADDR_W-1:0] a);
        return a[SRC_ID_MSB:SRC_ID_LSB];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State and slot bundles

    rxel_main_t st_r;
    rxel_main_t st_nxt;

    rxel_slot_if misc_sl();
    rxel_slot_if und_sl();
    rxel_slot_if ovr_sl();

    ////////////////////////////////////////////////////////////////////////
    // Bus phase decode

    logic setup_ph;
    logic wr_take;
    rxel_reg_t sel;
    logic [REG_W-1:0] wd16;
    logic [REG_W-1:0] wmask;

    // A write lands only at the access edge where pready is high
    // Read data is taken at the setup edge instead, so the answer
    // can come from a flip-flop with no wait state
    assign setup_ph = psel_i & ~penable_i;
    assign wr_take = psel_i & penable_i & st_r.pready & pwrite_i;
    assign sel = decode(paddr_i);
    assign wd16 = pwdata_i[REG_W-1:0];
    assign wmask = lane_mask(pstrb_i);

    ////////////////////////////////////////////////////////////////////////
    // Event qualification

    logic test_on;
    logic [EVT_N-1:0] evt_eff;
    logic [EV_MISC_N-1:0] misc_sel_hit;
    logic misc_evt;
    logic und_evt;
    logic ovr_evt;

    // Test mode makes every event fire every cycle it stays set
    // Software must clear it soon: the counters climb each cycle
    assign test_on = st_r.ctrl[CTL_TEST];
    assign evt_eff = evt_i | {EVT_N{test_on}}; // [R17]

    // Only kinds picked by the select bits count as misc errors
    // Status bits 9:5 still latch for kinds not selected
    assign misc_sel_hit = evt_i[EV_MISC_N-1:0] & st_r.ctrl[CTL_SEL_MSB:0]; // [R07]
    assign misc_evt = (|misc_sel_hit) | test_on; // [R09] [R10]
    assign und_evt = evt_i[EV_UNDERRUN] | test_on; // [R12] [R10]
    assign ovr_evt = evt_i[EV_OVERRUN] | test_on; // [R14] [R10]

    ////////////////////////////////////////////////////////////////////////
    // Slot requests; one increment per cycle however many kinds coincide
    // All decode stays here; a slot only sees strobes and data

    // Misc slot: ID loads with the count, selected kinds or test only
    assign misc_sl.inc = misc_evt; // [R09]
    assign misc_sl.load = misc_evt; // [R06] [R07] [R08]
    assign misc_sl.id_in = src_id(evt_addr_i); // [R06]
    assign misc_sl.wr_id = wr_take & (sel == RXEL_REG_MISC_ID);
    assign misc_sl.wr_cnt = wr_take & (sel == RXEL_REG_MISC_CNT);
    assign misc_sl.wdata = merge(misc_sl.wr_id ? misc_sl.id : misc_sl.count, wd16, pstrb_i);

    // Underrun slot
    assign und_sl.inc = und_evt; // [R12]
    assign und_sl.load = und_evt; // [R11] [R08]
    assign und_sl.id_in = src_id(evt_addr_i); // [R11]
    assign und_sl.wr_id = wr_take & (sel == RXEL_REG_UND_ID);
    assign und_sl.wr_cnt = wr_take & (sel == RXEL_REG_UND_CNT);
    assign und_sl.wdata = merge(und_sl.wr_id ? und_sl.id : und_sl.count, wd16, pstrb_i);

    // Overrun slot
    assign ovr_sl.inc = ovr_evt; // [R14]
    assign ovr_sl.load = ovr_evt; // [R13] [R08]
    assign ovr_sl.id_in = src_id(evt_addr_i); // [R13]
    assign ovr_sl.wr_id = wr_take & (sel == RXEL_REG_OVR_ID);
    assign ovr_sl.wr_cnt = wr_take & (sel == RXEL_REG_OVR_CNT);
    assign ovr_sl.wdata = merge(ovr_sl.wr_id ? ovr_sl.id : ovr_sl.count, wd16, pstrb_i);

    ////////////////////////////////////////////////////////////////////////
    // Slot instances
    // Identical slots; only the wiring above tells them apart

    rxel_event_slot #(
        .CNT_W(CNT_W)
    ) u_misc (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .sl(misc_sl)
    );

    rxel_event_slot #(
        .CNT_W(CNT_W)
    ) u_und (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .sl(und_sl)
    );

    rxel_event_slot #(
        .CNT_W(CNT_W)
    ) u_ovr (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .sl(ovr_sl)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read mux; reserved status bits are never stored, so read zero
    // Unmapped words fall to the default and read zero

    function automatic logic [REG_W-1:0] read_val(input rxel_reg_t r);
        logic [REG_W-1:0] v;
        v = '0;
        case (r)
            RXEL_REG_CTRL: v = st_r.ctrl;
            RXEL_REG_STATUS: v = st_r.status;
            RXEL_REG_MISC_ID: v = misc_sl.id;
            RXEL_REG_MISC_CNT: v = misc_sl.count;
            RXEL_REG_UND_ID: v = und_sl.id;
            RXEL_REG_UND_CNT: v = und_sl.count;
            RXEL_REG_OVR_ID: v = ovr_sl.id;
            RXEL_REG_OVR_CNT: v = ovr_sl.count;
            default: v = '0;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    logic [REG_W-1:0] sts_set;
    logic [REG_W-1:0] sts_clr;
    logic [REG_W-1:0] sts_hold;

    // Status set terms: errors, then counter wraps
    // A wrap arrives in the cycle of the increment itself
    always_comb begin
        sts_set = '0;
        sts_set[STS_EVT_MSB:STS_EVT_LSB] = evt_eff; // [R02] [R17]
        sts_set[STS_MISC_WRAP] = misc_sl.wrap; // [R04]
        sts_set[STS_UND_WRAP] = und_sl.wrap; // [R04]
        sts_set[STS_OVR_WRAP] = ovr_sl.wrap; // [R04]
    end

    // Write-one-to-clear on the enabled lanes only
    // Ones written to bits 4:0 clear nothing; those bits stay zero
    assign sts_clr = (wr_take && sel == RXEL_REG_STATUS) ? (wd16 & wmask) : '0; // [R03]
    assign sts_hold = st_r.status & ~sts_clr; // [R03]

    always_comb begin
        st_nxt = st_r;

        // A set in the clearing cycle beats the clear
        // so no event slips between a read and its clear
        st_nxt.status = sts_hold | sts_set; // [R02] [R03]
        // Summary re-asserts while any lower flag stands
        // Clearing it alone while others stand does nothing
        st_nxt.status[STS_SUMMARY] = sts_hold[STS_SUMMARY]
            | (|st_nxt.status[STS_OVR_WRAP:STS_EVT_LSB]); // [R05]
        st_nxt.status[STS_RSVD_MSB:0] = '0; // [R01]

        // Control word is plain read/write
        // Selects and test act from the next cycle, enables in the same cycle
        if (wr_take && sel == RXEL_REG_CTRL) begin
            st_nxt.ctrl = merge(st_r.ctrl, wd16, pstrb_i);
        end

        // Answer one cycle after setup; data caught at the setup edge
        // Data and error hold until the next setup, which is harmless
        st_nxt.pready = setup_ph;
        if (setup_ph) begin
            st_nxt.pslverr = (sel == RXEL_REG_NONE);
            st_nxt.rdata = pwrite_i ? '0 : read_val(sel);
        end

        // Service flag from flags that software has enabled
        // Built from next state, so it moves with the status bit
        st_nxt.service = |(st_nxt.status[CTL_IE_MSB:CTL_IE_LSB]
            & st_nxt.ctrl[CTL_IE_MSB:CTL_IE_LSB]); // [R16]
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; synchronous reset to all zero
    // The slots clear on the same edge from the same level

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_r <= '0; // [R15]
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops

    assign prdata_o = PDATA_W'(st_r.rdata);
    assign pready_o = st_r.pready;
    assign pslverr_o = st_r.pslverr;
    assign rx_path_service_flag_o = st_r.service;

endmodule

// File: rxel_event_log_sva.sv
// Port-level assertions for the receive event log.
// Bound from tb_top; sees only the top module's ports, one clock domain.
module rxel_event_log_sva
    import rxel_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [PADDR_W-1:0] paddr_i,
    input wire logic [PDATA_W-1:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [PDATA_W-1:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [EVT_N-1:0] evt_i,
    input wire logic [SRC_ADDR_W-1:0] evt_addr_i,
    input wire logic rx_path_service_flag_o
);
    localparam logic [PADDR_W-1:0] A_STS = IDX_STATUS << 2;
    logic setup, wr_done, mapped, any_evt;

    // Bus phases decoded once for all properties
    assign setup = psel_i && !penable_i;
    assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
    assign any_evt = |evt_i;
    assign mapped = paddr_i[1:0] == 2'b00 && (paddr_i >> 2) inside {IDX_CTRL, IDX_STATUS,
        IDX_MISC_ID, IDX_MISC_CNT, IDX_UND_ID, IDX_UND_CNT, IDX_OVR_ID, IDX_OVR_CNT};

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    ////////////////////////////////////////////////////////////////////////
    // Steps of a status read, and of an underrun seen by a later read
    sequence rd_sts;
        setup && !pwrite_i && paddr_i == A_STS;
    endsequence
    sequence und_then_rd;
        evt_i[EV_UNDERRUN] ##1 !wr_done ##1 rd_sts;
    endsequence

    a_ready_pulse: assert property (setup |=> pready_o ##1 !pready_o)
        else $error("pready is not a single access-cycle answer");
    a_unmapped_err: assert property (setup && !mapped |=> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (setup && mapped |=> !pslverr_o && prdata_o[31:16] == 16'h0)
        else $error("mapped access refused or upper half set");
    a_rsvd_zero: assert property (rd_sts |=> prdata_o[STS_RSVD_MSB:0] == 5'h00)
        else $error("status low bits not zero");
    a_summary_read: assert property (rd_sts |=>
        !(|prdata_o[STS_OVR_WRAP:STS_EVT_LSB]) || prdata_o[STS_SUMMARY])
        else $error("summary bit clear while a status bit stands");
    a_event_latch: assert property (und_then_rd |=> prdata_o[STS_EVT_LSB+EV_UNDERRUN])
        else $error("underrun not latched in status");
    a_flag_rise: assert property ($rose(rx_path_service_flag_o) |->
        $past(any_evt) || $past(wr_done))
        else $error("service flag rose without cause");
    a_flag_fall: assert property ($past(nrst_i) && $fell(rx_path_service_flag_o) |->
        $past(wr_done))
        else $error("service flag fell without a write");
    a_reset_quiet: assert property (disable iff (1'b0)
        !nrst_i |=> !pready_o && !rx_path_service_flag_o && prdata_o == 32'h0)
        else $error("outputs not cleared by reset");
endmodule

// File: tb_top.sv
// Self-checking bench for the receive event log, driven over APB.
// Assumes rxel_pkg and the checker are compiled before this file.
module tb_top
    import rxel_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [3:0] st = 4'hF;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, flag;
    logic [6:0] evt = 7'h00;
    logic [19:0] eaddr = 20'h00000;
    int failures = 0;
    int n_compared = 0;

    // 250 MHz
    always #2 clk_i = ~clk_i;

    rxel_event_log i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .evt_i(evt), .evt_addr_i(eaddr), .rx_path_service_flag_o(flag));

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= idx << 2;
        pwdata <= {16'h0000, d};
        pstrb <= st;
        @(posedge clk_i);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input string what, input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 16'h0000);
        chk(what, rd, exp);
    endtask

    // One-cycle event pulse with its structure address
    task automatic pulse(input logic [6:0] e, input logic [19:0] a);
        @(posedge clk_i);
        evt <= e;
        eaddr <= a;
        @(posedge clk_i);
        evt <= 7'h00;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        logic [15:0] r [8] = '{IDX_CTRL, IDX_STATUS, IDX_MISC_ID, IDX_MISC_CNT,
            IDX_UND_ID, IDX_UND_CNT, IDX_OVR_ID, IDX_OVR_CNT};
        foreach (r[i]) rdc("reset value", r[i], 32'h0);
        apb(1'b0, 16'h3001, 16'h0000);
        chk("unmapped err", err, 1'b1);
        chk("unmapped data", rd, 32'h0);
    endtask

    task automatic t_under_over();
        pulse(7'h20, 20'hABCDE);
        rdc("status", IDX_STATUS, 32'h8400);
        rdc("und id", IDX_UND_ID, 32'hABCD);
        rdc("und cnt", IDX_UND_CNT, 32'h1);
        // Both kinds in one cycle share one address
        pulse(7'h60, 20'h12345);
        rdc("status", IDX_STATUS, 32'h8C00);
        rdc("ovr id", IDX_OVR_ID, 32'h1234);
        rdc("ovr cnt", IDX_OVR_CNT, 32'h1);
        rdc("und cnt", IDX_UND_CNT, 32'h2);
        chk("service off", flag, 1'b0);
        apb(1'b1, IDX_STATUS, 16'h041F);
        rdc("status", IDX_STATUS, 32'h8800);
        apb(1'b1, IDX_STATUS, 16'h0800);
        rdc("status", IDX_STATUS, 32'h8000);
        apb(1'b1, IDX_STATUS, 16'h8000);
        rdc("status", IDX_STATUS, 32'h0);
    endtask

    // Each misc kind selected alone; a neighbour kind must not touch the misc ID or count
    task automatic t_misc();
        logic [19:0] a;
        logic [15:0] id_e;
        int j;
        id_e = 16'h0000;
        for (int k = 0; k < 5; k++) begin
            j = (k + 1) % 5;
            a = {4'(k + 1), 16'hC3A5};
            apb(1'b1, IDX_CTRL, 16'(1 << k) | 16'(1 << (k + 5)));
            pulse(7'(1 << j), 20'hFFFF0);
            rdc("misc id kept", IDX_MISC_ID, {16'h0, id_e});
            pulse(7'(1 << k), a);
            id_e = a[19:4];
            rdc("misc id", IDX_MISC_ID, {16'h0, id_e});
            rdc("misc cnt", IDX_MISC_CNT, 32'(k + 1));
            chk("service on", flag, 1'b1);
            rdc("misc status", IDX_STATUS, 32'h8000 | (32'h20 << k) | (32'h20 << j));
            apb(1'b1, IDX_STATUS, 16'hFFFF);
        end
        // Flag drops at the clearing edge; look one edge later
        @(posedge clk_i);
        chk("service off", flag, 1'b0);
    endtask

    // Test bit stands at three sampled edges: after the first write
    // lands, the next setup edge and the edge where the clear lands
    task automatic t_test();
        @(posedge clk_i);
        eaddr <= 20'h7E5D1;
        apb(1'b1, IDX_CTRL, 16'h8000);
        apb(1'b1, IDX_CTRL, 16'h0000);
        rdc("test status", IDX_STATUS, 32'h8FE0);
        rdc("test misc id", IDX_MISC_ID, 32'h7E5D);
        rdc("test und id", IDX_UND_ID, 32'h7E5D);
        rdc("test ovr id", IDX_OVR_ID, 32'h7E5D);
        rdc("test misc cnt", IDX_MISC_CNT, 32'h8);
        rdc("test und cnt", IDX_UND_CNT, 32'h5);
        rdc("test ovr cnt", IDX_OVR_CNT, 32'h4);
        apb(1'b1, IDX_STATUS, 16'hFFFF);
    endtask

    task automatic t_rw();
        logic [15:0] r [6] = '{IDX_MISC_ID, IDX_MISC_CNT, IDX_UND_ID, IDX_UND_CNT,
            IDX_OVR_ID, IDX_OVR_CNT};
        foreach (r[i]) begin
            apb(1'b1, r[i], 16'h5AC3);
            rdc("rw reg", r[i], 32'h5AC3);
        end
        // Only lane 0 enabled
        st = 4'h1;
        apb(1'b1, IDX_UND_ID, 16'hFFFF);
        st = 4'hF;
        rdc("strobe lane", IDX_UND_ID, 32'h5AFF);
    endtask

    task automatic t_wrap();
        logic [15:0] c [3] = '{IDX_MISC_CNT, IDX_UND_CNT, IDX_OVR_CNT};
        logic [6:0] e [3] = '{7'h01, 7'h20, 7'h40};
        logic [31:0] s [3] = '{32'h9020, 32'hA400, 32'hC800};
        apb(1'b1, IDX_CTRL, 16'h0001);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, c[k], 16'hFFFF);
            pulse(e[k], 20'h00000);
            rdc("wrap cnt", c[k], 32'h0);
            rdc("wrap flag", IDX_STATUS, s[k]);
            apb(1'b1, IDX_STATUS, 16'hFFFF);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_under_over();
        t_misc();
        t_test();
        t_rw();
        t_wrap();
        end_of_test();
    end

    // Watchdog, far beyond the 89 transfers above
    initial begin
        #40000;
        failures++;
        end_of_test();
    end
endmodule

bind rxel_event_log rxel_event_log_sva #(.CNT_W(CNT_W)) i_sva (.clk_i(clk_i), .nrst_i(nrst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .evt_i(evt_i), .evt_addr_i(evt_addr_i),
    .rx_path_service_flag_o(rx_path_service_flag_o));
